// File: include/afs_regs.svh
// Register addresses, reset values, field masks and timing counts
`ifndef AFS_REGS_SVH
`define AFS_REGS_SVH

// ----------------------------------------------------------------------
// Register addresses on the control port
// ----------------------------------------------------------------------
`define AFS_ADDR_SETUP1   6'h01
`define AFS_ADDR_SETUP2   6'h02
`define AFS_ADDR_SETUP3   6'h03
`define AFS_ADDR_DEVRST   6'h04
`define AFS_ADDR_CYCRST   6'h05

// ----------------------------------------------------------------------
// Reset values and writable bit masks
// ----------------------------------------------------------------------
`define AFS_RST_SETUP1    8'h03
`define AFS_RST_SETUP2    8'h20
`define AFS_RST_SETUP3    8'h1f
`define AFS_MASK_SETUP1   8'h7f
`define AFS_MASK_SETUP2   8'hef
`define AFS_MASK_SETUP3   8'hff
`define AFS_READ_ZERO     8'h00

// ----------------------------------------------------------------------
// Timing: master clocks per ADC clock, latency stages
// ----------------------------------------------------------------------
`define AFS_ADC_RATIO_STD 2'h2
`define AFS_ADC_RATIO_M3  2'h3
`define AFS_LAT_STAGES    3

`endif

// File: include/afs_pkg.sv
// Types shared by the setup register bank and its helpers
package afs_pkg;

  // Setup register one layout, msb first
  typedef struct packed {
    logic       reserved;
    logic       topSpeedFlag;
    logic [1:0] gainOutputShift;
    logic       perBlockPowerControl;
    logic       mono;
    logic       doubleSamplingSelect;
    logic       globalEnable;
  } afs_setup1_t;

  // Setup register two layout, msb first
  typedef struct packed {
    logic [1:0] outputLatencySel;
    logic       clampDacSpan;
    logic       zeroBit;
    logic       clampDacExternal;
    logic       outputPolarityFlip;
    logic [1:0] outputFormatSel;
  } afs_setup2_t;

  // Setup register three layout, msb first
  typedef struct packed {
    logic [1:0] monoInputPick;
    logic [1:0] resetSampleShift;
    logic [3:0] clampLevelCode;
  } afs_setup3_t;

  // Settings handed to the analogue path
  typedef struct packed {
    logic       doubleSamplingSelect;
    logic       mono;
    logic [1:0] gainOutputShift;
    logic       topSpeedFlag;
    logic       clampDacExternal;
    logic       clampDacSpan;
    logic [3:0] clampLevelCode;
    logic [1:0] resetSampleShift;
    logic [1:0] monoInputPick;
  } afs_analog_t;

  // Colour counter states
  typedef enum logic [1:0] {
    AFS_RED   = 2'b00,
    AFS_GREEN = 2'b01,
    AFS_BLUE  = 2'b10
  } afs_colour_t;

endpackage : afs_pkg

// File: core/afs_adc_divider.sv
// ADC clock tick generator from the master clock
`include "afs_regs.svh"
module afs_adc_divider
  import afs_pkg::*;
(
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic modeThree,
  output logic      adcTick
);

  logic [1:0] cnt_q;
  logic [1:0] ratio;

  // Two master clocks per ADC clock, three in mode three
  assign ratio = modeThree ? `AFS_ADC_RATIO_M3 : `AFS_ADC_RATIO_STD; // R13

  // Period counter
  always_ff @(posedge clk) begin
    if (rst) begin
      cnt_q   <= 2'h0;
      adcTick <= 1'b0;
    end else begin
      adcTick <= (cnt_q >= ratio - 2'h1); // R13
      cnt_q   <= (cnt_q >= ratio - 2'h1) ? 2'h0 : cnt_q + 2'h1;
    end
  end

endmodule : afs_adc_divider

// File: core/afs_latency_pipe.sv
// Output data delay line in whole ADC clock periods
module afs_latency_pipe
  import afs_pkg::*;
#(
  parameter int W      = 16,
  parameter int STAGES = 3
)
(
  input  wire logic         clk,
  input  wire logic         rst,
  input  wire logic         adcTick,
  input  wire logic [1:0]   latencySel,
  input  wire logic [W-1:0] dataIn,
  output logic [W-1:0]      dataOut
);

  logic [W-1:0] stage_q [0:STAGES-1];

  // Shift one stage per ADC clock, tap by latency code
  always_ff @(posedge clk) begin
    if (rst) begin
      for (int i = 0; i < STAGES; i++) begin
        stage_q[i] <= '0;
      end
      dataOut <= '0;
    end else if (adcTick) begin
      stage_q[0] <= dataIn;
      for (int i = 1; i < STAGES; i++) begin
        stage_q[i] <= stage_q[i-1];
      end
      dataOut <= (latencySel == 2'h0) ? dataIn : stage_q[latencySel - 2'h1]; // R12
    end
  end

endmodule : afs_latency_pipe

// File: core/afs_setup_bank.sv
// Setup register bank of the scanner front end with derived controls
//
// Contract
// (R1) Global enable powers device down or up only while per-block control is off.
// (R2) Setup one bit 1 picks single-ended or double sampling, default 1.
// (R3) Setup one bit 2 picks colour or monochrome, default 0.
// (R4) Setup one bit 3 enables per-block disabling by the four-bit mask.
// (R5) Gain output shift code sets output for zero differential input.
// (R6) Host sets top speed flag only in the fastest mode.
// (R7) Host writes zero to the reserved top bit of setup one.
// (R8) Output format field picks parallel, two halves or four nibbles.
// (R9) Polarity flip bit inverts output data digitally.
// (R10) Clamp external bit powers clamp DAC down, output high impedance.
// (R11) Clamp DAC span bit picks supply or top reference range, default 1.
// (R12) Latency field adds zero to three ADC clock periods of delay.
// (R13) ADC clock is two master clocks, three in mode three.
// (R14) Clamp level code drives the clamp DAC, default 1111.
// (R15) Reset sample shift moves the reset sample, default 01.
// (R16) Mono input pick selects red, green or blue; 11 reserved.
// (R17) Any write to the device reset address restores every default.
// (R18) Host should issue a device reset write after power-up.
// (R19) Any write to colour cycle reset returns counter to red.
// (R20) Registers sit at six-bit addresses 000001 to 000101.
// (R21) Line-sequential mode forces monochrome on and input pick 00.
`include "afs_regs.svh"
module afs_setup_bank
  import afs_pkg::*;
#(
  parameter int DATA_W = 16
)
(
  input  wire logic              clk,
  input  wire logic              rst,
  input  wire logic              wrEn,
  input  wire logic [5:0]        wrAddr,
  input  wire logic [7:0]        wrData,
  input  wire logic [5:0]        rdAddr,
  input  wire logic              lineSeqMode,
  input  wire logic [3:0]        blockDisableMask,
  input  wire logic              modeThree,
  input  wire logic              cyclePulsePin,
  input  wire logic [DATA_W-1:0] adcData,
  output logic [7:0]             rdData,
  output logic                   deviceOff,
  output logic [3:0]             blockOff,
  output afs_analog_t            analogCfg,
  output logic [1:0]             outputFormatSel,
  output logic                   adcTick,
  output logic [DATA_W-1:0]      outData,
  output afs_colour_t            colourSel
);

  // --------------------------------------------------------------------
  // Register state and write decode
  // --------------------------------------------------------------------
  afs_setup1_t setup1_q;
  afs_setup2_t setup2_q;
  afs_setup3_t setup3_q;
  logic        wrSetup1;
  logic        wrSetup2;
  logic        wrSetup3;
  logic        devReset;
  logic        cycReset;
  logic        cellRst;
  logic        pinMeta_q;
  logic        pinSync_q;
  logic        pinLast_q;
  logic        pinRise;
  logic [DATA_W-1:0] pipeIn;

  // Address decode of the control port
  assign wrSetup1 = wrEn && (wrAddr == `AFS_ADDR_SETUP1); // R20
  assign wrSetup2 = wrEn && (wrAddr == `AFS_ADDR_SETUP2); // R20
  assign wrSetup3 = wrEn && (wrAddr == `AFS_ADDR_SETUP3); // R20
  assign devReset = wrEn && (wrAddr == `AFS_ADDR_DEVRST); // R17
  assign cycReset = wrEn && (wrAddr == `AFS_ADDR_CYCRST); // R19

  // Whole-device reset: pin reset or strobe write
  assign cellRst = rst || devReset; // R17

  // --------------------------------------------------------------------
  // Setup registers
  // --------------------------------------------------------------------
  // Setup one; reserved top bit never stored
  always_ff @(posedge clk) begin
    if (cellRst) begin
      setup1_q <= afs_setup1_t'(`AFS_RST_SETUP1); // R17
    end else if (wrSetup1) begin
      setup1_q <= afs_setup1_t'(wrData & `AFS_MASK_SETUP1); // R7
    end
  end

  // Setup two; bit 4 held at zero
  always_ff @(posedge clk) begin
    if (cellRst) begin
      setup2_q <= afs_setup2_t'(`AFS_RST_SETUP2); // R17
    end else if (wrSetup2) begin
      setup2_q <= afs_setup2_t'(wrData & `AFS_MASK_SETUP2);
    end
  end

  // Setup three
  always_ff @(posedge clk) begin
    if (cellRst) begin
      setup3_q <= afs_setup3_t'(`AFS_RST_SETUP3); // R17
    end else if (wrSetup3) begin
      setup3_q <= afs_setup3_t'(wrData & `AFS_MASK_SETUP3);
    end
  end

  // --------------------------------------------------------------------
  // Read back
  // --------------------------------------------------------------------
  // Strobes and unmapped addresses read zero
  always_ff @(posedge clk) begin
    if (cellRst) begin
      rdData <= `AFS_READ_ZERO;
    end else begin
      case (rdAddr)
        `AFS_ADDR_SETUP1: rdData <= setup1_q;
        `AFS_ADDR_SETUP2: rdData <= setup2_q;
        `AFS_ADDR_SETUP3: rdData <= setup3_q;
        default:          rdData <= `AFS_READ_ZERO;
      endcase
    end
  end

  // --------------------------------------------------------------------
  // Power control
  // --------------------------------------------------------------------
  // Global enable only while per-block control is off
  always_ff @(posedge clk) begin
    if (cellRst) begin
      deviceOff <= 1'b0;
    end else begin
      deviceOff <= !setup1_q.perBlockPowerControl
                   && !setup1_q.globalEnable; // R1
    end
  end

  // Per-block disables only when selective control is on
  always_ff @(posedge clk) begin
    if (cellRst) begin
      blockOff <= 4'h0;
    end else begin
      blockOff <= setup1_q.perBlockPowerControl
                  ? blockDisableMask : 4'h0; // R4
    end
  end

  // --------------------------------------------------------------------
  // Analogue path settings
  // --------------------------------------------------------------------
  // Line-sequential mode overrides mono and input pick
  always_ff @(posedge clk) begin
    if (cellRst) begin
      analogCfg <= '0;
    end else begin
      analogCfg.doubleSamplingSelect <= setup1_q.doubleSamplingSelect; // R2
      analogCfg.mono <= lineSeqMode ? 1'b1 : setup1_q.mono; // R3 R21
      analogCfg.gainOutputShift  <= setup1_q.gainOutputShift; // R5
      analogCfg.topSpeedFlag     <= setup1_q.topSpeedFlag; // R6
      analogCfg.clampDacExternal <= setup2_q.clampDacExternal; // R10
      analogCfg.clampDacSpan     <= setup2_q.clampDacSpan; // R11
      analogCfg.clampLevelCode   <= setup3_q.clampLevelCode; // R14
      analogCfg.resetSampleShift <= setup3_q.resetSampleShift; // R15
      analogCfg.monoInputPick    <= lineSeqMode
                                    ? 2'h0 : setup3_q.monoInputPick; // R16 R21
    end
  end

  // Output word format to the output multiplexer
  always_ff @(posedge clk) begin
    if (cellRst) begin
      outputFormatSel <= 2'h0;
    end else begin
      outputFormatSel <= setup2_q.outputFormatSel; // R8
    end
  end

  // --------------------------------------------------------------------
  // Colour cycle counter
  // --------------------------------------------------------------------
  // Two-stage sync of the cycle pin, then edge detect
  always_ff @(posedge clk) begin
    if (cellRst) begin
      pinMeta_q <= 1'b0;
      pinSync_q <= 1'b0;
      pinLast_q <= 1'b0;
    end else begin
      pinMeta_q <= cyclePulsePin;
      pinSync_q <= pinMeta_q;
      pinLast_q <= pinSync_q;
    end
  end

  assign pinRise = pinSync_q && !pinLast_q;

  // Red, green, blue, red; reset write wins over a pulse
  always_ff @(posedge clk) begin
    if (cellRst || cycReset) begin
      colourSel <= AFS_RED; // R19
    end else if (lineSeqMode && pinRise) begin
      case (colourSel)
        AFS_RED:   colourSel <= AFS_GREEN;
        AFS_GREEN: colourSel <= AFS_BLUE;
        AFS_BLUE:  colourSel <= AFS_RED;
        default:   colourSel <= AFS_RED;
      endcase
    end
  end

  // --------------------------------------------------------------------
  // ADC clock and output data path
  // --------------------------------------------------------------------
  afs_adc_divider u_div (
    .clk       (clk),
    .rst       (cellRst),
    .modeThree (modeThree),
    .adcTick   (adcTick)
  );

  // Optional digital inversion ahead of the delay line
  assign pipeIn = setup2_q.outputPolarityFlip ? ~adcData : adcData; // R9

  afs_latency_pipe #(
    .W      (DATA_W),
    .STAGES (`AFS_LAT_STAGES)
  ) u_pipe (
    .clk        (clk),
    .rst        (cellRst),
    .adcTick    (adcTick),
    .latencySel (setup2_q.outputLatencySel),
    .dataIn     (pipeIn),
    .dataOut    (outData)
  );

  // --------------------------------------------------------------------
  // Assertions
  // --------------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  sequence devResetWrite;
    wrEn && (wrAddr == `AFS_ADDR_DEVRST);
  endsequence

  sequence defaultsBack;
    setup1_q == afs_setup1_t'(`AFS_RST_SETUP1)
    && setup2_q == afs_setup2_t'(`AFS_RST_SETUP2)
    && setup3_q == afs_setup3_t'(`AFS_RST_SETUP3);
  endsequence

  sequence monoTick;
    adcTick && modeThree && !devReset ##1 modeThree && !devReset
      ##1 modeThree && !devReset;
  endsequence

  globalPower_a: assert property ( // R1
    !devReset |=> deviceOff == $past(!setup1_q.perBlockPowerControl
                                     && !setup1_q.globalEnable))
    else $error("device power-down does not follow global enable");

  blockMask_a: assert property ( // R4
    !devReset |=> blockOff == ($past(setup1_q.perBlockPowerControl)
                               ? $past(blockDisableMask) : 4'h0))
    else $error("block disables do not follow the mask");

  lineSeqForce_a: assert property ( // R21
    lineSeqMode && !devReset |=> analogCfg.mono
                     && analogCfg.monoInputPick == 2'h0)
    else $error("line-sequential override missing");

  monoPick_a: assert property ( // R16
    !lineSeqMode && !devReset
      |=> analogCfg.monoInputPick == $past(setup3_q.monoInputPick)
          && analogCfg.mono == $past(setup1_q.mono))
    else $error("mono settings not passed through");

  devResetAll_a: assert property ( // R17
    devResetWrite |=> defaultsBack ##1 analogCfg.clampLevelCode == 4'hf)
    else $error("device reset write did not restore defaults");

  colourReset_a: assert property ( // R19
    wrEn && (wrAddr == `AFS_ADDR_CYCRST) |=> colourSel == AFS_RED)
    else $error("colour counter not returned to red");

  tickStd_a: assert property ( // R13
    adcTick && !modeThree && !devReset ##1 !modeThree && !devReset
      |-> !adcTick ##1 adcTick)
    else $error("ADC tick period not two clocks");

  tickMode3_a: assert property ( // R13
    monoTick |-> !adcTick ##1 adcTick)
    else $error("ADC tick period not three clocks");

  minLatency_a: assert property ( // R9
    adcTick && setup2_q.outputLatencySel == 2'h0 && !devReset
      |=> outData == $past(setup2_q.outputPolarityFlip
                           ? ~adcData : adcData))
    else $error("minimum latency or inversion wrong");

  sequence tickThenTick;
    adcTick && !devReset ##1 !devReset ##1 adcTick && !devReset;
  endsequence

  oneStage_a: assert property ( // R12
    tickThenTick ##0 setup2_q.outputLatencySel == 2'h1
      |=> outData == $past(pipeIn, 3))
    else $error("one-period latency tap broken");

  formatPass_a: assert property ( // R8
    !devReset |=> outputFormatSel == $past(setup2_q.outputFormatSel))
    else $error("output format not passed through");

  clampPass_a: assert property ( // R10
    !devReset |=> analogCfg.clampDacExternal
                  == $past(setup2_q.clampDacExternal)
                  && analogCfg.clampDacSpan == $past(setup2_q.clampDacSpan))
    else $error("clamp DAC controls not passed through");

  readBack_a: assert property ( // R20
    wrEn && wrAddr == `AFS_ADDR_SETUP3 ##1 rdAddr == `AFS_ADDR_SETUP3
      && !devReset |=> rdData == $past(wrData, 2))
    else $error("setup three read-back mismatch");

  sampPass_a: assert property ( // R2
    !devReset |=> analogCfg.doubleSamplingSelect
                  == $past(setup1_q.doubleSamplingSelect)
                  && analogCfg.topSpeedFlag == $past(setup1_q.topSpeedFlag))
    else $error("sampling style or speed flag not passed through");

  gainPass_a: assert property ( // R5
    !devReset |=> analogCfg.gainOutputShift
                  == $past(setup1_q.gainOutputShift))
    else $error("gain output shift not passed through");

  levelPass_a: assert property ( // R14 R15
    !devReset |=> analogCfg.clampLevelCode == $past(setup3_q.clampLevelCode)
                  && analogCfg.resetSampleShift
                     == $past(setup3_q.resetSampleShift))
    else $error("clamp level or reset sample shift not passed through");

  strobeRead_a: assert property ( // R20
    (rdAddr == `AFS_ADDR_DEVRST || rdAddr == `AFS_ADDR_CYCRST) && !devReset
      |=> rdData == `AFS_READ_ZERO)
    else $error("strobe location does not read zero");

endmodule : afs_setup_bank

// File: dv/afs_host_model.sv
// Host controller model issuing decoded register writes
`include "afs_regs.svh"
module afs_host_model
  import afs_pkg::*;
(
  input  wire logic  clk,
  output logic       wrEn,
  output logic [5:0] wrAddr,
  output logic [7:0] wrData
);
  timeunit 1ns;
  timeprecision 1ps;

  // ----------------------------------------------------------------
  // Write driver
  // ----------------------------------------------------------------
  // Idle bus at time zero
  initial begin
    wrEn   = 1'b0;
    wrAddr = 6'h00;
    wrData = 8'h00;
  end

  // One strobe cycle; idle bus shows inverted values, never stale ones
  task automatic doWrite(input logic [5:0] a, input logic [7:0] d);
    logic [7:0] v;
    v = (a == `AFS_ADDR_SETUP1) ? (d & 8'h7f) : d;
    @(negedge clk);
    wrEn   = 1'b1;
    wrAddr = a;
    wrData = v;
    @(negedge clk);
    wrEn   = 1'b0;
    wrAddr = ~a;
    wrData = ~v;
  endtask : doWrite
endmodule : afs_host_model

// File: dv/afs_setup_bank_tb.sv
// Self-checking bench for the setup register bank
`include "afs_regs.svh"
module afs_setup_bank_tb
  import afs_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  // ----------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------
  localparam logic [16:0] DEF_CFG =
    {1'h1, 1'h0, 2'h0, 1'h0, 1'h0, 1'h1, 4'hf, 2'h1, 2'h0};
  logic        clk;
  logic        rst;
  logic        wrEn;
  logic [5:0]  wrAddr;
  logic [7:0]  wrData;
  logic [5:0]  rdAddr;
  logic        lineSeqMode;
  logic [3:0]  blockDisableMask;
  logic        modeThree;
  logic        cyclePulsePin;
  logic [15:0] adcData;
  logic [7:0]  rdData;
  logic        deviceOff;
  logic [3:0]  blockOff;
  afs_analog_t analogCfg;
  logic [1:0]  outputFormatSel;
  logic        adcTick;
  logic [15:0] outData;
  afs_colour_t colourSel;
  int          err_total;
  int          n_compared;
  int          cyc;

  afs_setup_bank #(.DATA_W(16)) uut (
    .clk(clk), .rst(rst), .wrEn(wrEn), .wrAddr(wrAddr), .wrData(wrData),
    .rdAddr(rdAddr), .lineSeqMode(lineSeqMode),
    .blockDisableMask(blockDisableMask), .modeThree(modeThree),
    .cyclePulsePin(cyclePulsePin), .adcData(adcData), .rdData(rdData),
    .deviceOff(deviceOff), .blockOff(blockOff), .analogCfg(analogCfg),
    .outputFormatSel(outputFormatSel), .adcTick(adcTick),
    .outData(outData), .colourSel(colourSel));

  afs_host_model host (
    .clk(clk), .wrEn(wrEn), .wrAddr(wrAddr), .wrData(wrData));

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  // Clock at 50 MHz
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  // Hang guard
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      err_total++;
      end_of_test();
    end
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      err_total++;
      $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  task automatic end_of_test;
    $display("compared=%0d errors=%0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : end_of_test

  // Write, then let derived outputs settle
  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    host.doWrite(a, d);
    @(negedge clk);
  endtask : wr

  // Read data is registered, looked at one cycle later
  task automatic rd(input logic [5:0] a, input logic [7:0] e);
    @(negedge clk);
    rdAddr = a;
    @(negedge clk);
    check(32'(rdData), 32'(e));
  endtask : rd

  // Step past the next edge where a tick is taken
  task automatic waitTick;
    int n;
    n = 0;
    do begin
      @(negedge clk);
      n++;
    end while (adcTick !== 1'b1 && n < 8);
    @(negedge clk);
  endtask : waitTick

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic tDefaults;
    logic [7:0] defs [1:6];
    defs = '{8'h03, 8'h20, 8'h1f, 8'h00, 8'h00, 8'h00};
    check(32'(analogCfg), 32'(DEF_CFG));
    check(32'(deviceOff), 32'h0);
    for (int a = 1; a <= 6; a++) begin
      rd(6'(a), defs[a]);
    end
  endtask : tDefaults

  task automatic tFields;
    wr(`AFS_ADDR_SETUP1, 8'hb5);
    wr(`AFS_ADDR_SETUP3, 8'h96);
    rd(`AFS_ADDR_SETUP1, 8'h35);
    rd(`AFS_ADDR_SETUP3, 8'h96);
    check(32'(analogCfg),
      32'({1'h0, 1'h1, 2'h3, 1'h0, 1'h0, 1'h1, 4'h6, 2'h1, 2'h2}));
    wr(`AFS_ADDR_SETUP1, 8'h45);
    check(32'(analogCfg.topSpeedFlag), 32'h1);
    check(32'(analogCfg.doubleSamplingSelect), 32'h0);
    for (int i = 0; i < 4; i++) begin
      wr(`AFS_ADDR_SETUP1, {2'h0, 2'(i), 4'h3});
      wr(`AFS_ADDR_SETUP3, {2'(i % 3), 2'(i), 4'(i)});
      check(32'(analogCfg.gainOutputShift), 32'(i));
      check(32'(analogCfg.resetSampleShift), 32'(i));
      check(32'(analogCfg.clampLevelCode), 32'(i));
      check(32'(analogCfg.monoInputPick), 32'(i % 3));
    end
    wr(`AFS_ADDR_SETUP2, 8'h08);
    check(32'(analogCfg.clampDacExternal), 32'h1);
    check(32'(analogCfg.clampDacSpan), 32'h0);
    wr(`AFS_ADDR_SETUP2, 8'hff);
    rd(`AFS_ADDR_SETUP2, 8'hef);
  endtask : tFields

  task automatic tPower;
    logic [7:0] v [4];
    logic [4:0] e [4];
    v = '{8'h02, 8'h0a, 8'h0b, 8'h03};
    e = '{5'h10, 5'h0a, 5'h0a, 5'h00};
    blockDisableMask = 4'ha;
    for (int i = 0; i < 4; i++) begin
      wr(`AFS_ADDR_SETUP1, v[i]);
      check(32'({deviceOff, blockOff}), 32'(e[i]));
    end
  endtask : tPower

  task automatic tLatency;
    logic [15:0] oldV;
    logic [15:0] newV;
    for (int i = 0; i < 4; i++) begin
      wr(`AFS_ADDR_SETUP2, {2'(i), 2'h2, 1'h0, 1'(i), 2'(i)});
      check(32'(outputFormatSel), 32'(i));
      adcData = 16'h1234;
      repeat (6) waitTick();
      oldV = i[0] ? ~16'h1234 : 16'h1234;
      newV = i[0] ? ~16'hc0de : 16'hc0de;
      check(32'(outData), 32'(oldV));
      adcData = 16'hc0de;
      for (int k = 1; k <= i + 1; k++) begin
        waitTick();
        check(32'(outData), 32'((k <= i) ? oldV : newV));
      end
    end
  endtask : tLatency

  task automatic tTick;
    int n;
    for (int m = 0; m < 2; m++) begin
      modeThree = 1'(m);
      repeat (2) waitTick();
      n = 1;
      while (adcTick !== 1'b1 && n < 8) begin
        @(negedge clk);
        n++;
      end
      check(32'(n), 32'(2 + m));
    end
    modeThree = 1'b0;
  endtask : tTick

  task automatic tLineSeq;
    wr(`AFS_ADDR_SETUP1, 8'h03);
    wr(`AFS_ADDR_SETUP3, 8'h9f);
    lineSeqMode = 1'b1;
    repeat (2) @(negedge clk);
    check(32'(analogCfg.mono), 32'h1);
    check(32'(analogCfg.monoInputPick), 32'h0);
    cyclePulsePin = 1'b1;
    repeat (5) @(negedge clk);
    check(32'(colourSel), 32'(AFS_GREEN));
    cyclePulsePin = 1'b0;
    wr(`AFS_ADDR_CYCRST, 8'h77);
    check(32'(colourSel), 32'(AFS_RED));
    lineSeqMode = 1'b0;
    repeat (2) @(negedge clk);
    check(32'(analogCfg.monoInputPick), 32'h2);
  endtask : tLineSeq

  task automatic tDevReset;
    wr(`AFS_ADDR_SETUP2, 8'hc5);
    wr(`AFS_ADDR_SETUP1, 8'h30);
    wr(`AFS_ADDR_DEVRST, 8'ha5);
    check(32'(analogCfg), 32'(DEF_CFG));
    check(32'(deviceOff), 32'h0);
    rd(`AFS_ADDR_SETUP1, 8'h03);
    rd(`AFS_ADDR_SETUP2, 8'h20);
    rd(`AFS_ADDR_SETUP3, 8'h1f);
  endtask : tDevReset

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    err_total        = 0;
    n_compared       = 0;
    cyc              = 0;
    rst              = 1'b1;
    rdAddr           = 6'h00;
    lineSeqMode      = 1'b0;
    blockDisableMask = 4'h0;
    modeThree        = 1'b0;
    cyclePulsePin    = 1'b0;
    adcData          = 16'h0000;
    repeat (5) @(negedge clk);
    rst = 1'b0;
    wr(`AFS_ADDR_DEVRST, 8'h00);
    tDefaults();
    tFields();
    tPower();
    tLatency();
    tTick();
    tLineSeq();
    tDevReset();
    end_of_test();
  end
endmodule : afs_setup_bank_tb
